/* hw/patch_image_header_checker.sv */
// image checker: header parse, dword checksum, identity and platform match
// assumes: dwords arrive in ascending order, last one flagged by the loader
`timescale 1ns/10ps
`default_nettype none
`include "patch_check_defs.svh"

module patch_image_header_checker #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [31:0] word_i,
    input wire logic word_last_i,
    input wire logic word_valid_i,
    output logic word_ready_o,
    input wire logic [31:0] processor_id_i,
    input wire logic [2:0] platform_type_i,
    input wire logic result_ack_i,
    output logic pass_o,
    output logic fail_o,
    output logic fail_length_o,
    output logic fail_version_o,
    output logic fail_checksum_o,
    output logic fail_processor_o,
    output logic fail_platform_o,
    output logic [31:0] revision_o,
    output logic [31:0] date_o,
    output logic [31:0] loader_rev_o,
    input wire logic model_register_read_i,
    input wire logic [31:0] model_register_addr_i,
    output logic [63:0] model_register_data_o,
    output logic model_register_ack_o
);
    // -----------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------
    logic rst_meta, rst_n;

    // two flops release the reset in step with the clock
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // -----------------------------------------------------------------
    // input buffer and platform register
    // -----------------------------------------------------------------
    logic [32:0] drain_data;
    logic drain_valid, drain_ready;
    patch_check_pkg::dword_t word;
    logic last;
    patch_check_pkg::plat_type_t plat_type;

    image_fifo #(
        .WIDTH(33),
        .DEPTH(FIFO_DEPTH)
    ) i_image_fifo (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .fill_data_i({word_last_i, word_i}),
        .fill_valid_i(word_valid_i),
        .fill_ready_o(word_ready_o),
        .drain_data_o(drain_data),
        .drain_valid_o(drain_valid),
        .drain_ready_i(drain_ready)
    );

    platform_type_reg i_platform_type_reg (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .strap_i(platform_type_i),
        .read_i(model_register_read_i),
        .addr_i(model_register_addr_i),
        .data_o(model_register_data_o),
        .ack_o(model_register_ack_o),
        .type_o(plat_type)
    );

    assign word = drain_data[31:0];
    assign last = drain_data[32];

    // -----------------------------------------------------------------
    // checker state
    // -----------------------------------------------------------------
    patch_check_pkg::check_state_e state, next_state;
    logic [11:0] byte_cnt, next_byte_cnt;
    logic too_long, next_too_long;
    patch_check_pkg::dword_t sum, next_sum;
    patch_check_pkg::dword_t version, next_version;
    patch_check_pkg::dword_t revision, next_revision;
    patch_check_pkg::dword_t date, next_date;
    patch_check_pkg::dword_t proc_id, next_proc_id;
    patch_check_pkg::dword_t loader, next_loader;
    logic [`FLAG_BITS-1:0] flags, next_flags;
    logic pass, next_pass;
    logic [4:0] cause, next_cause;
    logic accept;

    // true when the dword now taken sits at the given byte offset
    function automatic logic at_field(input logic [11:0] pos,
                                      input logic [11:0] off);
        at_field = (pos == off);
    endfunction : at_field

    // one dword per handshake, none while a result is held
    assign drain_ready = (state == patch_check_pkg::st_collect);
    assign accept = drain_valid && drain_ready && ce_i;

    // next values of the checker
    always_comb begin
        next_state = state;
        next_byte_cnt = byte_cnt;
        next_too_long = too_long;
        next_sum = sum;
        next_version = version;
        next_revision = revision;
        next_date = date;
        next_proc_id = proc_id;
        next_loader = loader;
        next_flags = flags;
        next_pass = pass;
        next_cause = cause;
        unique case (state)
            patch_check_pkg::st_collect: begin
                if (accept) begin
                    next_sum = sum + word;
                    // count bytes, saturating past the image end
                    if (byte_cnt == `IMG_BYTES - `DWORD_BYTES) begin
                        next_too_long = too_long || !last;
                    end else if (!too_long) begin
                        next_byte_cnt = byte_cnt + `DWORD_BYTES;
                    end
                    // header capture; reserved span is skipped
                    if (!too_long) begin
                        if (at_field(byte_cnt, `OFF_VERSION)) begin
                            next_version = word;
                        end
                        if (at_field(byte_cnt, `OFF_REVISION)) begin
                            next_revision = word;
                        end
                        if (at_field(byte_cnt, `OFF_DATE)) begin
                            next_date = word;
                        end
                        if (at_field(byte_cnt, `OFF_PROCESSOR)) begin
                            next_proc_id = word;
                        end
                        if (at_field(byte_cnt, `OFF_LOADER)) begin
                            next_loader = word;
                        end
                        if (at_field(byte_cnt, `OFF_FLAGS)) begin
                            next_flags = word[`FLAG_BITS-1:0];
                        end
                    end
                    if (last) begin
                        next_state = patch_check_pkg::st_done;
                        next_cause[0] = too_long
                            || (byte_cnt != `LAST_WORD_BYTE);
                        next_cause[1] =
                            (next_version != `HDR_VERSION_1);
                        next_cause[2] = (next_sum != 32'h0000_0000);
                        next_cause[3] =
                            (next_proc_id != processor_id_i);
                        next_cause[4] = !next_flags[plat_type];
                        next_pass = 1'b1;
                        if (next_cause[0] || next_cause[1] || next_cause[2]
                            || next_cause[3] || next_cause[4]) begin
                            next_pass = 1'b0;
                        end
                    end
                end
            end
            patch_check_pkg::st_done: begin
                // result held until the loader takes it
                if (result_ack_i) begin
                    next_state = patch_check_pkg::st_collect;
                    next_byte_cnt = 12'h000;
                    next_too_long = 1'b0;
                    next_sum = `FIELD_RESET;
                    next_version = `FIELD_RESET;
                    next_proc_id = `FIELD_RESET;
                    next_flags = 8'h00;
                    next_pass = 1'b0;
                    next_cause = 5'h00;
                end
            end
        endcase
    end

    // checker registers
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= patch_check_pkg::st_collect;
            byte_cnt <= 12'h000;
            too_long <= 1'b0;
            sum <= `FIELD_RESET;
            version <= `FIELD_RESET;
            revision <= `FIELD_RESET;
            date <= `FIELD_RESET;
            proc_id <= `FIELD_RESET;
            loader <= `FIELD_RESET;
            flags <= 8'h00;
            pass <= 1'b0;
            cause <= 5'h00;
        end else if (ce_i) begin
            state <= next_state;
            byte_cnt <= next_byte_cnt;
            too_long <= next_too_long;
            sum <= next_sum;
            version <= next_version;
            revision <= next_revision;
            date <= next_date;
            proc_id <= next_proc_id;
            loader <= next_loader;
            flags <= next_flags;
            pass <= next_pass;
            cause <= next_cause;
        end
    end

    // -----------------------------------------------------------------
    // result outputs, all from flops
    // -----------------------------------------------------------------
    // one pass flag, or a fail flag with its causes
    assign pass_o = pass;
    assign fail_o = (cause != 5'h00);
    assign fail_length_o = cause[0];
    assign fail_version_o = cause[1];
    assign fail_checksum_o = cause[2];
    assign fail_processor_o = cause[3];
    assign fail_platform_o = cause[4];
    assign revision_o = revision;
    assign date_o = date;
    assign loader_rev_o = loader;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_last_taken;
        accept && last;
    endsequence

    sequence s_full_image_end;
        s_last_taken and (byte_cnt == `LAST_WORD_BYTE && !too_long);
    endsequence

    property p_flags_exclusive;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !(pass_o && fail_o) && (state != patch_check_pkg::st_collect
            || (!pass_o && !fail_o));
    endproperty
    a_flags_exclusive: assert property (p_flags_exclusive)
        else $error("pass and fail flags inconsistent");

    property p_done_stalls;
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_last_taken |=> !drain_ready && (pass_o || fail_o);
    endproperty
    a_done_stalls: assert property (p_done_stalls)
        else $error("checker kept taking dwords after the last one");

    property p_short_image;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (s_last_taken and (byte_cnt != `LAST_WORD_BYTE)) |=> fail_length_o;
    endproperty
    a_short_image: assert property (p_short_image)
        else $error("image of wrong length not flagged");

    property p_checksum;
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_last_taken |=> (fail_checksum_o == ($past(sum) + $past(word) != 0));
    endproperty
    a_checksum: assert property (p_checksum)
        else $error("checksum verdict disagrees with dword sum");

    property p_version;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (s_full_image_end and (version != `HDR_VERSION_1)) |=> fail_version_o;
    endproperty
    a_version: assert property (p_version)
        else $error("unknown header version accepted");

    property p_processor;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (s_full_image_end and (proc_id != processor_id_i))
            |=> fail_processor_o && !pass_o;
    endproperty
    a_processor: assert property (p_processor)
        else $error("image for another stepping not refused");

    property p_platform;
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_full_image_end |=> (fail_platform_o == !$past(flags[plat_type]));
    endproperty
    a_platform: assert property (p_platform)
        else $error("platform flag selection wrong");

    property p_hold_result;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (state == patch_check_pkg::st_done && !(ce_i && result_ack_i))
            |=> $stable(pass_o) && $stable(cause) && !drain_ready;
    endproperty
    a_hold_result: assert property (p_hold_result)
        else $error("result changed before it was taken");

    property p_capture;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (accept && !too_long && byte_cnt == `OFF_REVISION)
            |=> revision_o == $past(word);
    endproperty
    a_capture: assert property (p_capture)
        else $error("revision field not captured at its offset");

endmodule : patch_image_header_checker

`default_nettype wire

/* hw/patch_check_defs.svh */
// offsets, field positions, reset values and counts of the image checker
// assumes: included by bare name from the files under hw/
//
// What this block does
// - refuse image whose target stepping mismatches
// - image is exactly 2048 bytes, else invalid
// - first 48 bytes header, payload follows
// - accept only known header version one
// - header version at byte 0, 4 bytes
// - patch revision at byte 4, reported out
// - creation date mmddyyyy at byte 8
// - target processor identity at byte 12
// - checksum at byte 16 covers whole image
// - 512 dwords wrap-summed must equal zero
// - loader revision at byte 20, first one; code captures and reports it on loader_rev_o, does not check it
// - platform flags in low 8 bits, byte 24
// - bytes 28 to 47 reserved, ignored
// - platform register 64-bit read-only quadword
// - platform type in bits 52:50, rest reserved
// - platform type selects header flag bit
`ifndef PATCH_CHECK_DEFS_SVH
`define PATCH_CHECK_DEFS_SVH

// -----------------------------------------------------------------
// image geometry, counted in bytes
// -----------------------------------------------------------------
`define IMG_BYTES 12'h800
`define HDR_BYTES 12'h030
`define LAST_WORD_BYTE 12'h7FC
`define DWORD_BYTES 12'h004

// -----------------------------------------------------------------
// header field byte offsets
// -----------------------------------------------------------------
`define OFF_VERSION 12'h000
`define OFF_REVISION 12'h004
`define OFF_DATE 12'h008
`define OFF_PROCESSOR 12'h00C
`define OFF_CHECKSUM 12'h010
`define OFF_LOADER 12'h014
`define OFF_FLAGS 12'h018
`define OFF_RESERVED 12'h01C

// -----------------------------------------------------------------
// known values and reset values
// -----------------------------------------------------------------
`define HDR_VERSION_1 32'h0000_0001
`define LOADER_REV_1 32'h0000_0001
`define FIELD_RESET 32'h0000_0000
`define FLAG_BITS 8

// -----------------------------------------------------------------
// platform type register
// -----------------------------------------------------------------
`define PLAT_REG_ADDR 32'h0000_0017
`define PLAT_TYPE_LSB 50
`define PLAT_TYPE_MSB 52

`endif

/* hw/patch_check_pkg.sv */
// types shared by the image checker modules
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none

package patch_check_pkg;

    // checker sequencing
    typedef enum logic {
        st_collect,
        st_done
    } check_state_e;

    typedef logic [31:0] dword_t;
    typedef logic [2:0] plat_type_t;

endpackage : patch_check_pkg

`default_nettype wire

/* hw/image_fifo.sv */
// small first-in first-out buffer for the image dword stream
// assumes: one clock, asynchronous active-low reset, DEPTH a power of two
`timescale 1ns/10ps
`default_nettype none

module image_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] fill_data_i,
    input wire logic fill_valid_i,
    output logic fill_ready_o,
    output logic [WIDTH-1:0] drain_data_o,
    output logic drain_valid_o,
    input wire logic drain_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr;
    logic [PW-1:0] rd_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    // honest full and empty from the occupancy count
    assign fill_ready_o = (count != (PW+1)'(DEPTH));
    assign drain_valid_o = (count != '0);
    assign drain_data_o = mem[rd_ptr];
    assign push = fill_valid_i && fill_ready_o && ce_i;
    assign pop = drain_valid_o && drain_ready_i && ce_i;

    // pointer and count updates
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // registers; the store itself needs no reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce_i) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= fill_data_i;
        end
    end

endmodule : image_fifo

`default_nettype wire

/* hw/platform_type_reg.sv */
// read-only 64-bit platform type register behind the register read port
// assumes: strap stable around reset release, one clock
`timescale 1ns/10ps
`default_nettype none
`include "patch_check_defs.svh"

module platform_type_reg (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire patch_check_pkg::plat_type_t strap_i,
    input wire logic read_i,
    input wire logic [31:0] addr_i,
    output logic [63:0] data_o,
    output logic ack_o,
    output patch_check_pkg::plat_type_t type_o
);
    logic caught, next_caught;
    patch_check_pkg::plat_type_t plat, next_plat;
    logic [63:0] next_data;
    logic next_ack;

    // strap caught once after reset release; whole-quadword reads only
    always_comb begin
        next_caught = 1'b1;
        next_plat = caught ? plat : strap_i;
        next_ack = read_i;
        next_data = 64'h0000_0000_0000_0000;
        if (read_i && (addr_i == `PLAT_REG_ADDR)) begin
            next_data[`PLAT_TYPE_MSB:`PLAT_TYPE_LSB] = plat;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            caught <= 1'b0;
            plat <= 3'h0;
            data_o <= 64'h0000_0000_0000_0000;
            ack_o <= 1'b0;
        end else if (ce_i) begin
            caught <= next_caught;
            plat <= next_plat;
            data_o <= next_data;
            ack_o <= next_ack;
        end
    end

    assign type_o = plat;

    property p_plat_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && caught && read_i && addr_i == `PLAT_REG_ADDR)
            |=> (ack_o && data_o[`PLAT_TYPE_MSB:`PLAT_TYPE_LSB] == $past(plat)
                 && data_o[49:0] == 50'h0 && data_o[63:53] == 11'h0);
    endproperty
    a_plat_read: assert property (p_plat_read)
        else $error("platform register read returned wrong quadword");

endmodule : platform_type_reg

`default_nettype wire

/* dv/image_loader_model.sv */
// loader model: streams one stored image as dwords over valid/ready
// assumes: testbench fills img and pulses go_i at a falling edge
`timescale 1ns/10ps
`default_nettype none

module image_loader_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [9:0] count_i,
    input wire logic slow_i,
    input wire logic ready_i,
    output logic [31:0] word_o,
    output logic last_o,
    output logic valid_o,
    output logic busy_o
);
    logic [31:0] img [0:512];
    int idx = 0;
    logic taken = 1'b0;
    logic gap = 1'b0;
    logic go_q = 1'b0;

    initial begin
        word_o = 32'h0000_0000;
        last_o = 1'b0;
        valid_o = 1'b0;
        busy_o = 1'b0;
    end

    // present next dword, or release the lines to a changing value
    task automatic offer();
        gap = slow_i & ~gap;
        if (idx >= int'(count_i)) begin
            busy_o = 1'b0;
            valid_o = 1'b0;
            last_o = 1'b0;
            word_o = ~word_o;
        end else if (gap) begin
            valid_o = 1'b0;
            last_o = 1'b0;
            word_o = ~word_o;
        end else begin
            word_o = img[idx];
            last_o = (idx == int'(count_i) - 1);
            valid_o = 1'b1;
        end
    endtask : offer

    // note whether the offered dword was taken
    // start request sampled on the rising edge, clear of the falling one
    always @(posedge clk_i) begin
        taken <= valid_o & ready_i;
        go_q <= go_i;
    end

    // hold each dword until taken, then step up one address
    always @(negedge clk_i) begin
        if (go_q && !busy_o) begin
            busy_o = 1'b1;
            idx = 0;
            offer();
        end else if (busy_o && (!valid_o || taken)) begin
            if (valid_o) idx = idx + 1;
            offer();
        end
    end
endmodule : image_loader_model

`default_nettype wire

/* dv/patch_image_header_checker_tb.sv */
// testbench: image runs through the loader model, register reads
// assumes: design under hw/, loader model under dv/
`timescale 1ns/10ps
`default_nettype none

module patch_image_header_checker_tb;
    localparam logic [31:0] PROC = 32'h0000_0A51; // arbitrary identity
    localparam logic [31:0] REV = 32'h0000_0123;
    localparam logic [31:0] DATE = 32'h0718_2001;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] word_i;
    logic word_last_i, word_valid_i, word_ready_o, busy;
    logic [31:0] processor_id_i = PROC;
    logic [2:0] platform_type_i = 3'h0;
    logic result_ack_i = 1'b0;
    logic pass_o, fail_o, f_len, f_ver, f_cs, f_proc, f_plat;
    logic [31:0] revision_o, date_o, loader_rev_o;
    logic rd_i = 1'b0;
    logic [31:0] rd_addr = 32'h0000_0000;
    logic [63:0] rd_data;
    logic rd_ack;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [9:0] count = 10'h200;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    image_loader_model i_image_loader_model (.clk_i(ref_clk_i), .go_i(go),
        .count_i(count), .slow_i(slow), .ready_i(word_ready_o),
        .word_o(word_i), .last_o(word_last_i), .valid_o(word_valid_i),
        .busy_o(busy));

    patch_image_header_checker #(.FIFO_DEPTH(4)) i_patch_image_header_checker (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
        .word_i(word_i), .word_last_i(word_last_i),
        .word_valid_i(word_valid_i), .word_ready_o(word_ready_o),
        .processor_id_i(processor_id_i), .platform_type_i(platform_type_i),
        .result_ack_i(result_ack_i), .pass_o(pass_o), .fail_o(fail_o),
        .fail_length_o(f_len), .fail_version_o(f_ver),
        .fail_checksum_o(f_cs), .fail_processor_o(f_proc),
        .fail_platform_o(f_plat), .revision_o(revision_o), .date_o(date_o),
        .loader_rev_o(loader_rev_o), .model_register_read_i(rd_i),
        .model_register_addr_i(rd_addr), .model_register_data_o(rd_data),
        .model_register_ack_o(rd_ack));

    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // pass, fail, then causes: length version checksum processor platform
    function automatic logic [6:0] ex(input logic [4:0] c);
        return {c == 5'h00, c != 5'h00, c};
    endfunction : ex

    task automatic reset_dut();
        reset_n_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
    endtask : reset_dut

    task automatic rd(input logic [31:0] a, input logic [63:0] exp);
        @(negedge ref_clk_i);
        rd_i = 1'b1;
        rd_addr = a;
        @(negedge ref_clk_i);
        rd_i = 1'b0;
        check(rd_ack, 1'b1);
        check(rd_data, exp);
    endtask : rd

    // header in dwords 0..11, payload from byte 48, checksum to zero
    task automatic build(input logic [31:0] ver, input logic [31:0] pid,
                         input logic [31:0] flags);
        logic [31:0] sum;
        sum = 32'h0000_0000;
        for (int k = 0; k < 513; k++)
            i_image_loader_model.img[k] = (k < 12 || k == 512) ?
                32'hDEAD_BEEF : 32'(k);
        i_image_loader_model.img[512] = 32'h0000_0000;
        i_image_loader_model.img[0] = ver;
        i_image_loader_model.img[1] = REV;
        i_image_loader_model.img[2] = DATE;
        i_image_loader_model.img[3] = pid;
        i_image_loader_model.img[5] = 32'h0000_0001;
        i_image_loader_model.img[6] = flags;
        for (int k = 0; k < 512; k++)
            if (k != 4) sum += i_image_loader_model.img[k];
        i_image_loader_model.img[4] = -sum;
    endtask : build

    task automatic start(input logic [9:0] n, input logic s);
        @(negedge ref_clk_i);
        count = n;
        slow = s;
        go = 1'b1;
        @(negedge ref_clk_i);
        go = 1'b0;
    endtask : start

    task automatic await(input logic [6:0] exp);
        for (int i = 0; i < 3000 && pass_o !== 1'b1 && fail_o !== 1'b1; i++)
            @(negedge ref_clk_i);
        if (pass_o !== 1'b1 && fail_o !== 1'b1) begin
            n_mismatch++;
            close_out();
        end else begin
            check({busy, pass_o, fail_o, f_len, f_ver, f_cs, f_proc, f_plat},
                {1'b0, exp});
        end
    endtask : await

    task automatic ack();
        result_ack_i = 1'b1;
        @(negedge ref_clk_i);
        result_ack_i = 1'b0;
        @(negedge ref_clk_i);
        check({pass_o, fail_o}, 2'b00);
    endtask : ack

    task automatic run(input logic [9:0] n, input logic [6:0] exp);
        start(n, 1'b0);
        await(exp);
        ack();
    endtask : run

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        for (int t = 0; t < 8; t++) begin
            platform_type_i = 3'(t);
            reset_dut();
            rd(32'h0000_0017, {11'h000, 3'(t), 50'h0});
            rd(32'h0000_0018, 64'h0);
            build(32'h1, PROC, 32'hFFFF_FF00 | (32'h1 << t));
            start(10'h200, t[0]);
            await(ex(5'h00));
            ack();
            build(32'h1, PROC, 32'hFFFF_FFFF ^ (32'h1 << t));
            run(10'h200, ex(5'h01));
        end
        check({revision_o, date_o}, {REV, DATE});
        check(loader_rev_o, 32'h0000_0001);
        build(32'h2, PROC, 32'h80);
        run(10'h200, ex(5'h08));
        build(32'h1, PROC ^ 32'h1, 32'h80);
        run(10'h200, ex(5'h02));
        i_image_loader_model.img[300] ^= 32'h1;
        run(10'h200, ex(5'h06));
        build(32'h1, PROC, 32'h80);
        run(10'h1FF, ex(5'h14));
        run(10'h201, ex(5'h10));
        // result held: second image fills the buffer until refused
        start(10'h200, 1'b0);
        await(ex(5'h00));
        start(10'h200, 1'b1);
        repeat (20) @(negedge ref_clk_i);
        check(word_ready_o, 1'b0);
        ack();
        await(ex(5'h00));
        ack();
        close_out();
    end
endmodule : patch_image_header_checker_tb

`default_nettype wire
